// ===== logic/pbd_bar_decode.sv
// Inbound memory window decoder with Avalon-MM setup registers
//
// Notes on behaviour
// - Endpoint mode offers six 32-bit windows or three 64-bit ones.
// - Root port mode offers two 32-bit windows or one 64-bit one.
// - Windows zero, two and four may be set 32-bit or 64-bit.
// - Odd windows are 32-bit only; off when the window below is enabled and 64-bit.
// - 32-bit window sizes run from 4 KB to 2 GB.
// - 64-bit window sizes run from 4 KB to 256 GB; memory only.
// - Every window is memory space; I/O requests never hit.
// - An active 64-bit window reads as prefetchable; a 32-bit or inactive one does not.
// - An enabled window claims only addresses inside its aperture.
// - On a hit the window base is swapped for its local base.
// - A disabled window claims nothing.
`timescale 1ns/10ps
`default_nettype none
`include "pbd_defines.svh"

module pbd_bar_decode (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic reqValid,
	input wire pbd_pkg::pbd_req_t reqIn,
	output logic rspValid,
	output pbd_pkg::pbd_rsp_t rspOut
);

	// ==========================================================
	// Bus slave handshake

	logic access;
	logic done_q;
	logic doWrite;
	logic [2:0] wSel;
	logic [2:0] wReg;
	logic globalSel;

	// Every access answers on its second cycle
	assign access = avs_read | avs_write;
	assign avs_waitrequest = access & ~done_q;
	assign doWrite = avs_write & done_q;
	assign wSel = avs_address[`PBD_WSEL_HI:`PBD_WSEL_LO];
	assign wReg = avs_address[`PBD_WREG_HI:`PBD_WREG_LO];
	assign globalSel = (wSel == `PBD_WSEL_GLOBAL);

	// Done flag closes the access at the second edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= access & ~done_q;
		end
	end

	// Merge write data under byte enables
	function automatic logic [31:0] pbdMerge(
		input logic [31:0] oldVal,
		input logic [31:0] newVal,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = newVal[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Clamp a requested size to the range the width allows
	function automatic logic [5:0] pbdClamp(
		input logic [5:0] req,
		input logic w64
	);
		logic [5:0] top;
		top = w64 ? `PBD_SZ_MAX64 : `PBD_SZ_MAX32;
		if (req < `PBD_SZ_MIN) begin
			return `PBD_SZ_MIN;
		end
		if (req > top) begin
			return top;
		end
		return req;
	endfunction

	// ==========================================================
	// Global mode register

	logic rootPort_q;
	logic modeWr;

	assign modeWr = doWrite & globalSel
		& (avs_address == `PBD_OFS_MODE) & avs_byteenable[0];

	// Port type selects endpoint or root port window limits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rootPort_q <= 1'b0;
		end else if (modeWr) begin
			rootPort_q <= avs_writedata[`PBD_MODE_RP];
		end
	end

	// ==========================================================
	// Per-window registers and matchers

	logic [`PBD_NUM_WIN-1:0] en_q;
	logic [`PBD_NUM_WIN-1:0] w64_q;
	logic [`PBD_NUM_WIN-1:0] effEn;
	logic [`PBD_NUM_WIN-1:0] eff64;
	logic [`PBD_NUM_WIN-1:0] winHit;
	logic [5:0] size_q [`PBD_NUM_WIN];
	logic [31:0] baseLo_q [`PBD_NUM_WIN];
	logic [31:0] baseHi_q [`PBD_NUM_WIN];
	logic [31:0] xlatLo_q [`PBD_NUM_WIN];
	logic [31:0] xlatHi_q [`PBD_NUM_WIN];
	logic [31:0] ctrlRd [`PBD_NUM_WIN];
	logic [63:0] winLocal [`PBD_NUM_WIN];
	pbd_pkg::pbd_win_cfg_t winCfg [`PBD_NUM_WIN];

	genvar gi;
	generate
		for (gi = 0; gi < `PBD_NUM_WIN; gi++) begin : gWin
			logic wrSel;
			logic [31:0] ctrlNew;
			logic newW64;
			logic shadowed;
			logic rpBlocked;

			assign wrSel = doWrite & (wSel == 3'(gi + 1));
			assign ctrlNew = pbdMerge(ctrlRd[gi], avs_writedata,
				avs_byteenable);

			if (gi % 2 == 0) begin : gEven
				assign newW64 = ctrlNew[`PBD_CTRL_W64];
				assign shadowed = 1'b0;
			end else begin : gOdd
				assign newW64 = 1'b0;
				// upper half of the 64-bit window below
				assign shadowed = en_q[gi-1] & w64_q[gi-1];
			end

			// root port keeps only the first two windows
			if (gi < `PBD_RP_WIN) begin : gRpOk
				assign rpBlocked = 1'b0;
			end else begin : gRpCut
				assign rpBlocked = rootPort_q;
			end

			// Control word: enable, width and size
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					en_q[gi] <= 1'b0;
					w64_q[gi] <= 1'b0;
					size_q[gi] <= `PBD_RST_SZ;
				end else if (wrSel && wReg == `PBD_WREG_CTRL) begin
					en_q[gi] <= ctrlNew[`PBD_CTRL_EN];
					w64_q[gi] <= newW64;
					size_q[gi] <= pbdClamp(
						ctrlNew[`PBD_CTRL_SZ_HI:`PBD_CTRL_SZ_LO], newW64);
				end
			end

			// Link-side base address halves
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					baseLo_q[gi] <= `PBD_RST_WORD;
					baseHi_q[gi] <= `PBD_RST_WORD;
				end else if (wrSel && wReg == `PBD_WREG_BASE_LO) begin
					baseLo_q[gi] <= pbdMerge(baseLo_q[gi], avs_writedata,
						avs_byteenable);
				end else if (wrSel && wReg == `PBD_WREG_BASE_HI) begin
					baseHi_q[gi] <= pbdMerge(baseHi_q[gi], avs_writedata,
						avs_byteenable);
				end
			end

			// Local bus translation base halves
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					xlatLo_q[gi] <= `PBD_RST_WORD;
					xlatHi_q[gi] <= `PBD_RST_WORD;
				end else if (wrSel && wReg == `PBD_WREG_XLAT_LO) begin
					xlatLo_q[gi] <= pbdMerge(xlatLo_q[gi], avs_writedata,
						avs_byteenable);
				end else if (wrSel && wReg == `PBD_WREG_XLAT_HI) begin
					xlatHi_q[gi] <= pbdMerge(xlatHi_q[gi], avs_writedata,
						avs_byteenable);
				end
			end

			// at most three 64-bit windows via shadowing
			assign effEn[gi] = en_q[gi] & ~shadowed & ~rpBlocked;
			assign eff64[gi] = effEn[gi] & w64_q[gi];

			// Readback of control with live status bits
			always_comb begin
				ctrlRd[gi] = `PBD_RST_WORD;
				ctrlRd[gi][`PBD_CTRL_EN] = en_q[gi];
				ctrlRd[gi][`PBD_CTRL_W64] = w64_q[gi];
				ctrlRd[gi][`PBD_CTRL_PF] = eff64[gi];
				ctrlRd[gi][`PBD_CTRL_ACT] = effEn[gi];
				ctrlRd[gi][`PBD_CTRL_SZ_HI:`PBD_CTRL_SZ_LO] = size_q[gi];
			end

			// Matcher setup; 32-bit windows ignore the high base
			assign winCfg[gi].enable = effEn[gi];
			assign winCfg[gi].is64 = eff64[gi];
			assign winCfg[gi].sizeLog2 = size_q[gi];
			assign winCfg[gi].base = {eff64[gi] ? baseHi_q[gi]
				: `PBD_RST_WORD, baseLo_q[gi]};
			assign winCfg[gi].xlat = {xlatHi_q[gi], xlatLo_q[gi]};

			pbd_window_match uMatch (
				.cfg(winCfg[gi]),
				.addr(reqIn.addr),
				.isIo(reqIn.isIo),
				.hit(winHit[gi]),
				.localAddr(winLocal[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Hit selection; the lowest window wins on overlap

	pbd_pkg::pbd_rsp_t rsp_d;

	always_comb begin
		rsp_d = '0;
		rsp_d.localAddr = reqIn.addr;
		for (int w = `PBD_NUM_WIN - 1; w >= 0; w--) begin
			if (winHit[w]) begin
				rsp_d.hit = 1'b1;
				rsp_d.window = 3'(w);
				rsp_d.prefetch = eff64[w];
				rsp_d.localAddr = winLocal[w];
			end
		end
	end

	// ==========================================================
	// Registered decode result

	logic rspValid_q;
	pbd_pkg::pbd_rsp_t rsp_q;

	// One result per request, one cycle later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rspValid_q <= 1'b0;
			rsp_q <= '0;
		end else begin
			rspValid_q <= reqValid;
			if (reqValid) begin
				rsp_q <= rsp_d;
			end
		end
	end

	assign rspValid = rspValid_q;
	assign rspOut = rsp_q;

	// ==========================================================
	// Statistics: hit and miss counts, last outcome

	logic [31:0] hits_q;
	logic [31:0] misses_q;
	logic [3:0] last_q;
	logic hitsClr;
	logic missClr;

	assign hitsClr = doWrite && avs_address == `PBD_OFS_HITS;
	assign missClr = doWrite && avs_address == `PBD_OFS_MISSES;

	// A clear in the same cycle as a hit restarts the count at one
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hits_q <= `PBD_RST_WORD;
		end else if (reqValid && rsp_d.hit) begin
			hits_q <= (hitsClr ? `PBD_RST_WORD : hits_q) + 32'h1;
		end else if (hitsClr) begin
			hits_q <= `PBD_RST_WORD;
		end
	end

	// Misses count requests that no window claimed
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			misses_q <= `PBD_RST_WORD;
		end else if (reqValid && !rsp_d.hit) begin
			misses_q <= (missClr ? `PBD_RST_WORD : misses_q) + 32'h1;
		end else if (missClr) begin
			misses_q <= `PBD_RST_WORD;
		end
	end

	// Last decode outcome: hit flag and window
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= 4'h0;
		end else if (reqValid) begin
			last_q <= {rsp_d.hit, rsp_d.window};
		end
	end

	// ==========================================================
	// Read data mux, captured in the first cycle of an access

	logic [31:0] rd_d;
	logic [31:0] rd_q;
	logic [2:0] wIdx;
	logic winValid;

	assign wIdx = wSel - `PBD_WSEL_FIRST;
	assign winValid = !globalSel && wIdx < 3'(`PBD_NUM_WIN);

	// Unmapped addresses read as zero
	always_comb begin
		rd_d = `PBD_RST_WORD;
		if (globalSel) begin
			unique case (avs_address)
				`PBD_OFS_MODE: rd_d[`PBD_MODE_RP] = rootPort_q;
				`PBD_OFS_STATUS: begin
					rd_d[`PBD_STAT_EN_LO +: `PBD_NUM_WIN] = effEn;
					rd_d[`PBD_STAT_PF_LO +: `PBD_NUM_WIN] = eff64;
					rd_d[`PBD_STAT_RP] = rootPort_q;
				end
				`PBD_OFS_HITS: rd_d = hits_q;
				`PBD_OFS_MISSES: rd_d = misses_q;
				`PBD_OFS_LAST: rd_d[`PBD_LAST_HIT:0] = last_q;
				default: rd_d = `PBD_RST_WORD;
			endcase
		end else if (winValid) begin
			unique case (wReg)
				`PBD_WREG_CTRL: rd_d = ctrlRd[wIdx];
				`PBD_WREG_BASE_LO: rd_d = baseLo_q[wIdx];
				`PBD_WREG_BASE_HI: rd_d = baseHi_q[wIdx];
				`PBD_WREG_XLAT_LO: rd_d = xlatLo_q[wIdx];
				`PBD_WREG_XLAT_HI: rd_d = xlatHi_q[wIdx];
				default: rd_d = `PBD_RST_WORD;
			endcase
		end
	end

	// Read data held steady into the answering cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= `PBD_RST_WORD;
		end else if (avs_read && !done_q) begin
			rd_q <= rd_d;
		end
	end

	assign avs_readdata = rd_q;

endmodule

`default_nettype wire

// ===== logic/pbd_defines.svh
// Constants for the inbound window decoder: offsets, fields, limits
`ifndef PBD_DEFINES_SVH
`define PBD_DEFINES_SVH

// ==========================================================
// Geometry
`define PBD_NUM_WIN 6
`define PBD_RP_WIN 2
`define PBD_AW 8
`define PBD_DW 32

// ==========================================================
// Global register offsets (byte addresses)
`define PBD_OFS_MODE 8'h00
`define PBD_OFS_STATUS 8'h04
`define PBD_OFS_HITS 8'h08
`define PBD_OFS_MISSES 8'h0C
`define PBD_OFS_LAST 8'h10

// ==========================================================
// Window register blocks: window n sits at (n+1)*0x20
`define PBD_WSEL_HI 7
`define PBD_WSEL_LO 5
`define PBD_WSEL_GLOBAL 3'h0
`define PBD_WSEL_FIRST 3'h1
`define PBD_WREG_HI 4
`define PBD_WREG_LO 2
`define PBD_WREG_CTRL 3'h0
`define PBD_WREG_BASE_LO 3'h1
`define PBD_WREG_BASE_HI 3'h2
`define PBD_WREG_XLAT_LO 3'h3
`define PBD_WREG_XLAT_HI 3'h4

// ==========================================================
// Window control fields
`define PBD_CTRL_EN 0
`define PBD_CTRL_W64 1
`define PBD_CTRL_PF 2
`define PBD_CTRL_ACT 3
`define PBD_CTRL_SZ_LO 8
`define PBD_CTRL_SZ_HI 13

// ==========================================================
// Status and last-hit fields
`define PBD_STAT_EN_LO 0
`define PBD_STAT_PF_LO 8
`define PBD_STAT_RP 16
`define PBD_MODE_RP 0
`define PBD_LAST_HIT 3

// ==========================================================
// Aperture size limits as log2 of bytes, and reset values
`define PBD_SZ_MIN 6'h0C
`define PBD_SZ_MAX32 6'h1F
`define PBD_SZ_MAX64 6'h26
`define PBD_RST_SZ 6'h0C
`define PBD_RST_WORD 32'h0000_0000

`endif

// ===== logic/pbd_pkg.sv
// Types shared by the inbound window decoder
`default_nettype none
package pbd_pkg;

	// Effective setup of one window as the matcher sees it
	typedef struct packed {
		logic enable;
		logic is64;
		logic [5:0] sizeLog2;
		logic [63:0] base;
		logic [63:0] xlat;
	} pbd_win_cfg_t;

	// Inbound request from the link side
	typedef struct packed {
		logic [63:0] addr;
		logic isIo;
	} pbd_req_t;

	// Decode result toward the local bus
	typedef struct packed {
		logic hit;
		logic [2:0] window;
		logic prefetch;
		logic [63:0] localAddr;
	} pbd_rsp_t;

endpackage

`default_nettype wire

// ===== logic/pbd_window_match.sv
// Aperture compare and base replacement for one window
`timescale 1ns/10ps
`default_nettype none

module pbd_window_match (
	input wire pbd_pkg::pbd_win_cfg_t cfg,
	input wire logic [63:0] addr,
	input wire logic isIo,
	output logic hit,
	output logic [63:0] localAddr
);

	logic [63:0] offMask;
	logic upperOk;

	// Offset bits below the power-of-two size
	// offset mask
	assign offMask = (64'h1 << cfg.sizeLog2) - 64'h1;

	// A 32-bit window only sees the low 4 GB
	assign upperOk = cfg.is64 | (addr[63:32] == 32'h0000_0000);

	assign hit = cfg.enable & ~isIo & upperOk
		& (((addr ^ cfg.base) & ~offMask) == 64'h0);

	assign localAddr = (cfg.xlat & ~offMask) | (addr & offMask);

endmodule

`default_nettype wire

// ===== verification/pbd_bar_decode_props.sv
// Assertion checker for the inbound window decoder
`timescale 1ns/10ps
`default_nettype none
module pbd_bar_decode_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic reqValid,
	input wire pbd_pkg::pbd_req_t reqIn,
	input wire logic rspValid,
	input wire pbd_pkg::pbd_rsp_t rspOut
);
	// ==========================================================
	// Clocking and request outcomes
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_hit;
		reqValid ##1 rspOut.hit;
	endsequence
	sequence s_miss;
		reqValid ##1 !rspOut.hit;
	endsequence
	// ==========================================================
	// Properties
	a_rsp_one_after: assert property (reqValid |=> rspValid)
		else $error("response pulse missing");
	a_no_stray_rsp: assert property (!reqValid |=> !rspValid)
		else $error("response without request");
	a_rsp_holds: assert property (!reqValid |=> $stable(rspOut))
		else $error("result changed without request");
	a_io_never_hit: assert property (
		reqValid && reqIn.isIo |=> !rspOut.hit)
		else $error("io request hit");
	a_miss_passes: assert property (s_miss |->
		rspOut.localAddr == $past(reqIn.addr) && !rspOut.prefetch
		&& rspOut.window == 3'h0)
		else $error("miss result wrong");
	a_offset_kept: assert property (s_hit |->
		rspOut.localAddr[11:0] == $past(reqIn.addr[11:0]))
		else $error("offset bits altered");
	a_window_range: assert property (s_hit |-> rspOut.window <= 3'h5)
		else $error("window index out of range");
	a_odd_no_pf: assert property (s_hit |->
		!(rspOut.window[0] && rspOut.prefetch))
		else $error("odd window prefetchable");
	a_narrow_low: assert property (s_hit ##0 !rspOut.prefetch |->
		$past(reqIn.addr[63:32]) == 32'h0000_0000)
		else $error("32-bit window hit above 4 GB");
	a_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest longer than one cycle");
endmodule
bind pbd_bar_decode pbd_bar_decode_props u_props (.clk_sys(clk_sys),
	.rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .reqValid(reqValid),
	.reqIn(reqIn), .rspValid(rspValid), .rspOut(rspOut));
`default_nettype wire

// ===== verification/pbd_rc_model.sv
// Root complex model issuing inbound memory requests
`timescale 1ns/10ps
`default_nettype none
module pbd_rc_model (
	input wire logic clk_sys,
	output logic reqValid,
	output pbd_pkg::pbd_req_t reqIn
);
	// Idle lines at time zero
	initial begin
		reqValid = 1'h0;
		reqIn = '0;
	end
	// One request after an idle gap; released lines scrambled
	task automatic send(input logic [63:0] a, input logic io, input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		reqValid <= 1'h1;
		reqIn <= '{addr: a, isIo: io};
		@(posedge clk_sys);
		reqValid <= 1'h0;
		reqIn <= ~reqIn;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the inbound window decoder
`timescale 1ns/10ps
`default_nettype none
`include "pbd_defines.svh"
module tb_top;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'h0;
	logic avsWrite = 1'h0;
	logic [31:0] avsWritedata = 32'h0000_0000;
	logic [3:0] avsByteenable = 4'hF;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic reqValid;
	pbd_pkg::pbd_req_t reqIn;
	logic rspValid;
	pbd_pkg::pbd_rsp_t rspOut;
	int n_fail = 0;
	int compares = 0;
	int eHits = 0;
	int eMiss = 0;
	logic [3:0] eLast = 4'h0;
	logic eEn[6];
	logic eW64[6];
	logic [5:0] eSz[6];
	logic [63:0] eBase[6];
	logic [63:0] eXlat[6];
	logic rootMode = 1'h0;
	// ==========================================================
	// Design, partner, clock
	pbd_bar_decode u_pbd_bar_decode (.clk_sys(clk_sys), .rst_n(rst_n),
		.avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
		.avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
		.reqValid(reqValid), .reqIn(reqIn), .rspValid(rspValid),
		.rspOut(rspOut));
	pbd_rc_model rc (.clk_sys(clk_sys), .reqValid(reqValid), .reqIn(reqIn));
	always #4 clk_sys = ~clk_sys;
	// ==========================================================
	// Expectations
	function automatic logic live(input int n);
		return eEn[n] && !(n % 2 == 1 && eEn[n & 6] && eW64[n & 6])
			&& !(rootMode && n > 1);
	endfunction
	function automatic pbd_pkg::pbd_rsp_t exp_rsp(logic [63:0] a, logic io);
		pbd_pkg::pbd_rsp_t r;
		logic [63:0] m;
		r = '{1'h0, 3'h0, 1'h0, a};
		for (int n = 5; n >= 0; n--) begin
			m = ~64'h0 << eSz[n];
			if (!io && live(n) && (eW64[n] || a[63:32] == 32'h0)
				&& (a & m) == (eBase[n] & m)) begin
				r = '{1'h1, 3'(n), eW64[n], (eXlat[n] & m) | (a & ~m)};
			end
		end
		return r;
	endfunction
	function automatic logic [31:0] stat_exp();
		logic [31:0] s;
		s = {15'h0, rootMode, 16'h0};
		for (int n = 0; n < 6; n++) begin
			s[n] = live(n);
			s[n + 8] = live(n) && eW64[n];
		end
		return s;
	endfunction
	function automatic logic [7:0] wa(input int n, input logic [2:0] r);
		return {3'(n + 1), r, 2'h0};
	endfunction
	// ==========================================================
	// Checks and bus cycles
	task automatic chk(logic [63:0] got, logic [63:0] exp, string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic av(logic wr, logic [7:0] ad, logic [31:0] wd,
		output logic [31:0] rd);
		int k = 0;
		@(posedge clk_sys);
		avsRead <= !wr;
		avsWrite <= wr;
		avsAddress <= ad;
		avsWritedata <= wd;
		do begin
			@(negedge clk_sys);
			k++;
		end while (avsWaitrequest !== 1'h0 && k < 50);
		@(posedge clk_sys);
		rd = avsReaddata;
		chk(64'(k < 50), 64'h1, "bus answer");
		avsRead <= 1'h0;
		avsWrite <= 1'h0;
	endtask
	task automatic wr(logic [7:0] ad, logic [31:0] d);
		logic [31:0] x;
		av(1'h1, ad, d, x);
	endtask
	task automatic rd(logic [7:0] ad, logic [31:0] mask, logic [31:0] e);
		logic [31:0] d;
		av(1'h0, ad, 32'h0000_0000, d);
		chk(64'(d & mask), 64'(e), "register");
	endtask
	task automatic cfg(int n, logic e, logic w, logic [5:0] s,
		logic [63:0] b, logic [63:0] x);
		logic [5:0] c;
		c = s < 6'h0C ? 6'h0C : (w && s > 6'h26) ? 6'h26
			: (!w && s > 6'h1F) ? 6'h1F : s;
		eEn[n] = e;
		eW64[n] = w;
		eSz[n] = c;
		eBase[n] = w ? b : {32'h0, b[31:0]};
		eXlat[n] = x;
		wr(wa(n, `PBD_WREG_CTRL), {18'h0, s, 6'h0, w, e});
		wr(wa(n, `PBD_WREG_BASE_LO), b[31:0]);
		wr(wa(n, `PBD_WREG_BASE_HI), b[63:32]);
		wr(wa(n, `PBD_WREG_XLAT_LO), x[31:0]);
		wr(wa(n, `PBD_WREG_XLAT_HI), x[63:32]);
		rd(wa(n, `PBD_WREG_CTRL), 32'h0000_3F03, {18'h0, c, 6'h0, w, e});
	endtask
	task automatic probe(logic [63:0] a, logic io);
		pbd_pkg::pbd_rsp_t e;
		e = exp_rsp(a, io);
		if (e.hit)
			eHits++;
		else
			eMiss++;
		eLast = {e.hit, e.window};
		rc.send(a, io, $urandom_range(2));
		@(negedge clk_sys);
		chk(64'(rspValid), 64'h1, "valid");
		chk(rspOut.localAddr, e.localAddr, "local address");
		chk(64'({rspOut.hit, rspOut.window, rspOut.prefetch}),
			64'({e.hit, e.window, e.prefetch}), "hit fields");
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Watchdog
	initial begin
		#400000;
		n_fail++;
		print_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		int n;
		logic [63:0] a;
		void'($urandom(48004));
		for (int i = 0; i < 6; i++) begin
			eEn[i] = 1'h0;
			eW64[i] = 1'h0;
			eSz[i] = 6'h0C;
			eBase[i] = 64'h0;
			eXlat[i] = 64'h0;
		end
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		rd(`PBD_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(wa(0, `PBD_WREG_CTRL), 32'hFFFF_FFFF, 32'h0000_0C00);
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(8'h34, 32'hFFFF_FFFF, 32'h0000_0000);
		cfg(0, 1'h1, 1'h0, 6'h0C, 64'h1000_0000, 64'h8000_0000);
		for (int i = -1; i < 2; i++) begin
			probe(64'h1000_0000 + 64'(i * 4096), 1'h0);
			probe(64'h1000_0FFF + 64'(i * 4096), 1'h0);
		end
		cfg(2, 1'h1, 1'h1, 6'h26, 64'h40_0000_0000, {$urandom, $urandom});
		cfg(3, 1'h1, 1'h0, 6'h0C, 64'h2000_0000, 64'h0);
		probe(64'h2000_0010, 1'h0);
		probe(64'h7F_FFFF_FFFF, 1'h0);
		rd(`PBD_OFS_STATUS, 32'hFFFF_FFFF, stat_exp());
		cfg(1, 1'h1, 1'h0, 6'h3F, 64'h8000_0000, {32'h0, $urandom});
		cfg(4, 1'h1, 1'h1, 6'h05, {$urandom, 32'h0}, {$urandom, $urandom});
		cfg(5, 1'h0, 1'h0, 6'h0C, 64'h3000_0000, 64'h0);
		for (int i = 0; i < 150; i++) begin
			n = $urandom_range(5);
			a = eBase[n] ^ ({$urandom, $urandom} & ~(~64'h0 << (eSz[n] + 1)));
			if (i % 10 == 0)
				a = {$urandom, $urandom};
			probe(a, $urandom_range(7) == 0);
		end
		probe(64'h40_0000_0100, 1'h1);
		cfg(0, 1'h0, 1'h0, 6'h0C, 64'h1000_0000, 64'h0);
		probe(64'h1000_0000, 1'h0);
		wr(`PBD_OFS_MODE, 32'h0000_0001);
		rootMode = 1'h1;
		rd(`PBD_OFS_STATUS, 32'hFFFF_FFFF, stat_exp());
		probe(64'h40_0000_0000, 1'h0);
		probe(64'h8000_0040, 1'h0);
		rd(`PBD_OFS_MODE, 32'hFFFF_FFFF, 32'h0000_0001);
		rd(`PBD_OFS_HITS, 32'hFFFF_FFFF, 32'(eHits));
		rd(`PBD_OFS_MISSES, 32'hFFFF_FFFF, 32'(eMiss));
		rd(`PBD_OFS_LAST, 32'hFFFF_FFFF, {28'h0, eLast});
		wr(`PBD_OFS_HITS, 32'h0000_0000);
		rd(`PBD_OFS_HITS, 32'hFFFF_FFFF, 32'h0000_0000);
		// Partial write: only byte lane one lands
		avsByteenable <= 4'h2;
		wr(wa(5, `PBD_WREG_XLAT_LO), 32'hAABB_CCDD);
		avsByteenable <= 4'hF;
		rd(wa(5, `PBD_WREG_XLAT_LO), 32'hFFFF_FFFF, 32'h0000_CC00);
		// Reset in mid-run returns every window to off
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		rootMode = 1'h0;
		rd(`PBD_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(`PBD_OFS_MISSES, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(`PBD_OFS_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
		print_verdict();
	end
endmodule
`default_nettype wire
